// file: aer_alarm_event_register.sv
/*
  Alarm event collector: status, enable mask and latch-enable registers
  for fourteen alarm conditions, with an active count and one interrupt.
  Assumes event conditions arrive as synchronous levels and that a
  nonvolatile store outside accepts a one-cycle save pulse.
  Assumes the host sends a clear request and then its confirm as the next
  control write; other registers may be written in between.
  Condition pin 13 is not used: the power-on event has its own pin and is
  gated by the power-on delay register.
*/
// What this block does
// - Fourteen alarm events are tracked, coded zero through D.
// - Each event has a status bit, an enable mask bit and a latch-enable bit.
// - The status register is read-only, one bit per active or held event.
// - A count of the events indicated active in the status register is reported.
// - An event whose mask bit is clear is neither processed nor recorded.
// - After factory reset only the power-on event is enabled.
// - After factory reset no event is latched.
// - An enabled unlatched event shows only while its condition lasts.
// - A latched event stays set until the host clears the status register or clears its enable mask bit.
// - The status clears only after a request followed by an affirmative confirm.
// - The status register is volatile and all-clear after reset.
// - Mask and latch settings are sent to nonvolatile storage on a save request.
// - The power-on event is raised only when the power-on delay is above zero.
`default_nettype none
module aer_alarm_event_register (
  input wire logic clock_i, // 125 MHz clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [13:0] cond_i, // raw alarm conditions, one per code
  input wire logic power_on_i, // level high while power-on phase lasts
  input wire logic [3:0] addr_i, // register address
  input wire logic [31:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [31:0] rdata_o, // read data, cycle after rd_i
  output logic irq_o, // level interrupt
  output logic nv_save_o, // pulse: store mask and latch now
  output logic [13:0] nv_mask_o, // mask value to store
  output logic [13:0] nv_latch_o, // latch value to store
  output logic [3:0] active_count_o // number of status bits set
);
  typedef enum logic [1:0] {AER_IDLE, AER_ARMED} aer_clr_state_t;

  // Register map, by word index on addr_i:
  //   0 status, read-only;
  //   1 enable mask;
  //   2 latch enable;
  //   3 active count, read-only;
  //   4 control: clear request, clear confirm, save;
  //   5 interrupt status, write one to clear;
  //   6 interrupt mask;
  //   7 power-on delay.
  // Status bits by event code:
  //   0 high flow;
  //   1 low flow;
  //   2 flow between the limits;
  //   3 first totalizer over its volume limit;
  //   4 second totalizer over its volume limit;
  //   5 high pressure;
  //   6 low pressure;
  //   7 pressure between the limits;
  //   8 first temperature limit;
  //   9 second temperature limit;
  //   A temperature between the limits;
  //   B pulse output queue overflow;
  //   C attempt to change the password;
  //   D power on.

  // Software-visible registers.
  logic [13:0] alarm_status;
  logic [13:0] alarm_enable_mask;
  logic [13:0] alarm_latch_enable;
  logic [7:0] poweron_delay;
  logic [2:0] irq_status;
  logic [2:0] next_irq_status;
  logic [2:0] irq_mask;
  logic [13:0] trigger;
  logic [13:0] next_status;
  logic [13:0] new_set;
  logic clear_now;
  logic save_now;
  logic [3:0] next_count;
  logic [2:0] irq_events;
  logic [31:0] read_word;
  // Decoded write strobes.
  logic ctrl_wr;
  logic mask_wr;
  logic latch_wr;
  logic delay_wr;
  logic irq_stat_wr;
  logic irq_mask_wr;
  // Held state of the two-step clear.
  aer_clr_state_t clr_state;
  aer_clr_state_t next_clr_state;

  // Counts the set bits of a status word.
  function automatic logic [3:0] aer_popcount(input logic [13:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 14; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  // True for a write strobe at the given register offset.
  function automatic logic is_wr(input logic w, input logic [3:0] a, input logic [3:0] off);
    return w && (a == off);
  endfunction

  // One decoded strobe per writable register keeps the update blocks short.
  assign ctrl_wr = is_wr(wr_i, addr_i, aer_pkg::OFF_CTRL);
  assign mask_wr = is_wr(wr_i, addr_i, aer_pkg::OFF_MASK);
  assign latch_wr = is_wr(wr_i, addr_i, aer_pkg::OFF_LATCH);
  assign delay_wr = is_wr(wr_i, addr_i, aer_pkg::OFF_POWERON_DLY);
  assign irq_stat_wr = is_wr(wr_i, addr_i, aer_pkg::OFF_IRQ_STAT);
  assign irq_mask_wr = is_wr(wr_i, addr_i, aer_pkg::OFF_IRQ_MASK);

  // Codes zero through C follow their condition pins; code D is the
  // power-on event and only counts with a nonzero delay.
  for (genvar e = 0; e < 14; e++) begin : g_trigger
    if (e == aer_pkg::EV_POWER_ON) begin : g_power
      assign trigger[e] = power_on_i && (poweron_delay != 8'h00);
    end else begin : g_plain
      assign trigger[e] = cond_i[e];
    end
  end

  // Two-step clear: a request arms, the next control write clears if it
  // confirms. Any other control write while armed withdraws the request, so
  // a stray write can never clear the held alarms on its own.
  always_comb begin
    next_clr_state = clr_state;
    if (ctrl_wr) begin
      case (clr_state)
        AER_IDLE: begin
          if (wdata_i[aer_pkg::CTRL_CLEAR_REQ]) begin
            next_clr_state = AER_ARMED;
          end
        end
        AER_ARMED: begin
          next_clr_state = AER_IDLE;
        end
        default: begin
          next_clr_state = AER_IDLE;
        end
      endcase
    end
  end

  // Writes to other registers leave an armed request in place.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      clr_state <= AER_IDLE;
    end else begin
      clr_state <= next_clr_state;
    end
  end

  assign clear_now = ctrl_wr && (clr_state == AER_ARMED)
    && wdata_i[aer_pkg::CTRL_CLEAR_CONFIRM];
  assign save_now = ctrl_wr && wdata_i[aer_pkg::CTRL_SAVE];

  // A held bit survives only for a latched, enabled event and drops on a
  // confirmed clear; a fresh trigger is OR-ed in after the clear, so an
  // event that arrives in the clear cycle is not lost.
  for (genvar g = 0; g < 14; g++) begin : g_event
    logic present;
    logic held;
    assign present = trigger[g];
    assign held = alarm_latch_enable[g] && alarm_status[g] && !clear_now;
    assign next_status[g] = alarm_enable_mask[g] && (present || held);
  end

  // An interrupt cause is a status bit that rises, not one that stays set.
  assign new_set = next_status & ~alarm_status;

  // Status is volatile: a reset returns every alarm to clear.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      alarm_status <= 14'h0000;
    end else begin
      alarm_status <= next_status;
    end
  end

  assign next_count = aer_popcount(next_status);

  // The count is taken from the next status value so that it changes in the
  // same cycle as the status register it describes.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      active_count_o <= 4'h0;
    end else begin
      active_count_o <= next_count;
    end
  end

  // Configuration registers; a mask change acts at once, while the copy in
  // nonvolatile storage only follows a save request.
  // Enable mask, power-on event only after reset.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      alarm_enable_mask <= aer_pkg::MASK_DEFAULT;
    end else if (mask_wr) begin
      alarm_enable_mask <= wdata_i[13:0];
    end
  end

  // Latch enable, no event held after reset.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      alarm_latch_enable <= aer_pkg::LATCH_DEFAULT;
    end else if (latch_wr) begin
      alarm_latch_enable <= wdata_i[13:0];
    end
  end

  // A zero delay keeps the power-on event silent.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      poweron_delay <= aer_pkg::POWERON_DLY_DEFAULT;
    end else if (delay_wr) begin
      poweron_delay <= wdata_i[7:0];
    end
  end

  // Every interrupt cause is masked after reset.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_mask <= 3'h0;
    end else if (irq_mask_wr) begin
      irq_mask <= wdata_i[2:0];
    end
  end

  // Snapshot for the nonvolatile store; the store keeps what it receives.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      nv_save_o <= 1'b0;
    end else begin
      nv_save_o <= save_now;
    end
  end

  // The mask copy only moves together with the save pulse.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      nv_mask_o <= 14'h0000;
    end else if (save_now) begin
      nv_mask_o <= alarm_enable_mask;
    end
  end

  // The latch copy only moves together with the save pulse.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      nv_latch_o <= 14'h0000;
    end else if (save_now) begin
      nv_latch_o <= alarm_latch_enable;
    end
  end

  // Interrupt causes: a new status bit, a confirmed clear, a save.
  always_comb begin
    irq_events = 3'h0;
    irq_events[aer_pkg::IRQ_NEW_EVENT] = |new_set;
    irq_events[aer_pkg::IRQ_CLEARED] = clear_now;
    irq_events[aer_pkg::IRQ_SAVED] = save_now;
  end

  // Hardware set wins over a write-one-to-clear in the same cycle.
  always_comb begin
    next_irq_status = irq_status;
    if (irq_stat_wr) begin
      next_irq_status = irq_status & ~wdata_i[2:0];
    end
    next_irq_status = next_irq_status | irq_events;
  end

  // Interrupt causes stay until software clears them.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_status <= 3'h0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Level output: high while any unmasked cause is pending.
  assign irq_o = |(irq_status & irq_mask);

  // Read multiplexer; reserved upper bits and unmapped addresses read as zero.
  always_comb begin
    read_word = 32'h0000_0000;
    case (addr_i)
      aer_pkg::OFF_STATUS: begin
        read_word = {18'h0, alarm_status};
      end
      aer_pkg::OFF_MASK: begin
        read_word = {18'h0, alarm_enable_mask};
      end
      aer_pkg::OFF_LATCH: begin
        read_word = {18'h0, alarm_latch_enable};
      end
      aer_pkg::OFF_COUNT: begin
        read_word = {28'h0, active_count_o};
      end
      aer_pkg::OFF_CTRL: begin
        // Control reads back only whether a clear is armed.
        read_word = {31'h0, clr_state == AER_ARMED};
      end
      aer_pkg::OFF_IRQ_STAT: begin
        read_word = {29'h0, irq_status};
      end
      aer_pkg::OFF_IRQ_MASK: begin
        read_word = {29'h0, irq_mask};
      end
      aer_pkg::OFF_POWERON_DLY: begin
        read_word = {24'h0, poweron_delay};
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe and are zero otherwise,
  // so a late sample by the host cannot pick up a stale word.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= read_word;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// file: aer_chk.sv
/*
  Port checker for the alarm event collector.
  Assumes it is bound to aer_alarm_event_register and sees only its ports.
*/
`default_nettype none
module aer_chk (
  input wire logic clock_i, // clock
  input wire logic rst_i, // reset, active high
  input wire logic [3:0] addr_i, // address
  input wire logic [31:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [31:0] rdata_o, // read data
  input wire logic irq_o, // interrupt
  input wire logic nv_save_o, // save pulse
  input wire logic [13:0] nv_mask_o, // saved mask
  input wire logic [3:0] active_count_o // active count
);
  logic save_wr;
  assign save_wr = wr_i && addr_i == aer_pkg::OFF_CTRL && wdata_i[aer_pkg::CTRL_SAVE];
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not idle");
  read_high_a: assert property (rd_i |=> rdata_o[31:14] == 18'h0)
    else $error("read data upper bits set");
  save_pulse_a: assert property (nv_save_o |=> !nv_save_o)
    else $error("save pulse too long");
  save_need_a: assert property (save_wr |=> nv_save_o)
    else $error("save pulse missing");
  save_cause_a: assert property (nv_save_o |-> $past(save_wr))
    else $error("save pulse without write");
  nv_hold_a: assert property ($changed(nv_mask_o) |-> nv_save_o)
    else $error("stored mask moved without save");
  count_max_a: assert property (active_count_o <= 4'hE)
    else $error("count above event total");
  reset_clean_a: assert property ($fell(rst_i) |-> active_count_o == 4'h0 && !irq_o)
    else $error("state not clear after reset");
  cover property (nv_save_o);
  cover property (irq_o);
  cover property (active_count_o == 4'h2);
endmodule
bind aer_alarm_event_register aer_chk i_aer_chk (.clock_i, .rst_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .irq_o, .nv_save_o, .nv_mask_o, .active_count_o);
`default_nettype wire

// file: aer_pkg.sv
/*
  Constants for the alarm event collector: register offsets, widths,
  factory defaults and event codes.
  Assumes a single 125 MHz clock and a plain strobe register port.
*/
`default_nettype none
package aer_pkg;
  localparam int unsigned NUM_EVENTS = 14;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned COUNT_W = 4;

  // Register word indices on addr_i.
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_MASK = 4'h1;
  localparam logic [3:0] OFF_LATCH = 4'h2;
  localparam logic [3:0] OFF_COUNT = 4'h3;
  localparam logic [3:0] OFF_CTRL = 4'h4;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h5;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h6;
  localparam logic [3:0] OFF_POWERON_DLY = 4'h7;

  // Control register fields.
  localparam int unsigned CTRL_CLEAR_REQ = 0;
  localparam int unsigned CTRL_CLEAR_CONFIRM = 1;
  localparam int unsigned CTRL_SAVE = 2;

  // Interrupt status fields.
  localparam int unsigned IRQ_NEW_EVENT = 0;
  localparam int unsigned IRQ_CLEARED = 1;
  localparam int unsigned IRQ_SAVED = 2;
  localparam int unsigned IRQ_W = 3;

  // Event codes 0 through D.
  localparam int unsigned EV_POWER_ON = 13;

  // Factory defaults: only the power-on event enabled, no latching.
  localparam logic [13:0] MASK_DEFAULT = 14'h2000;
  localparam logic [13:0] LATCH_DEFAULT = 14'h0000;
  localparam logic [7:0] POWERON_DLY_DEFAULT = 8'h00;
endpackage
`default_nettype wire

// file: test_alarm_event_register.sv
/*
  Self-checking bench for the alarm event collector.
  Assumes the package, design and checker are compiled before it.
*/
`default_nettype none
module test_alarm_event_register;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [13:0] cond_i = 14'h0;
  logic power_on_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic irq_o, nv_save_o;
  logic [13:0] nv_mask_o, nv_latch_o;
  logic [3:0] active_count_o;
  int fails = 0;
  int tests_run = 0;
  always #4 clock_i = ~clock_i;
  aer_alarm_event_register i_aer_alarm_event_register (.clock_i, .rst_i, .cond_i,
    .power_on_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o, .nv_save_o,
    .nv_mask_o, .nv_latch_o, .active_count_o);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  // Status is read two edges after a stimulus change, so the update has landed.
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string n);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(n, e, rdata_o);
  endtask
  task automatic t_reset;
    rd(4'h0, 32'h0, "status");
    rd(4'h1, 32'h2000, "mask");
    rd(4'h2, 32'h0, "latch");
    rd(4'h9, 32'h0, "unmapped");
    chk("irq", 32'h0, 32'(irq_o));
  endtask
  task automatic t_mask;
    @(posedge clock_i);
    cond_i <= 14'h0003;
    power_on_i <= 1'b1;
    rd(4'h0, 32'h0, "masked");
    wr(4'h7, 32'h1);
    rd(4'h7, 32'h1, "delay");
    rd(4'h0, 32'h2000, "power on");
    @(posedge clock_i);
    power_on_i <= 1'b0;
    cond_i <= 14'h0;
  endtask
  task automatic t_follow;
    wr(4'h1, 32'h1FFF);
    cond_i <= 14'h0005;
    wr(4'h0, 32'h3FFF);
    rd(4'h0, 32'h5, "follow");
    rd(4'h3, 32'h2, "count");
    chk("count port", 32'h2, 32'(active_count_o));
    @(posedge clock_i);
    cond_i <= 14'h0;
    rd(4'h0, 32'h0, "drop");
  endtask
  task automatic t_latch;
    wr(4'h6, 32'h2);
    rd(4'h6, 32'h2, "irq mask");
    wr(4'h2, 32'h6);
    cond_i <= 14'h0002;
    @(posedge clock_i);
    cond_i <= 14'h0;
    rd(4'h0, 32'h2, "held");
    chk("irq masked", 32'h0, 32'(irq_o));
    wr(4'h4, 32'h1);
    rd(4'h4, 32'h1, "armed");
    wr(4'h4, 32'h0);
    rd(4'h4, 32'h0, "disarmed");
    wr(4'h4, 32'h2);
    rd(4'h0, 32'h2, "no confirm");
    wr(4'h4, 32'h1);
    @(posedge clock_i);
    addr_i <= 4'h4;
    wdata_i <= 32'h2;
    wr_i <= 1'b1;
    cond_i <= 14'h0004;
    @(posedge clock_i);
    wr_i <= 1'b0;
    cond_i <= 14'h0;
    rd(4'h0, 32'h4, "clear race");
    chk("irq raised", 32'h1, 32'(irq_o));
    wr(4'h5, 32'h2);
    #1 chk("irq cleared", 32'h0, 32'(irq_o));
  endtask
  task automatic t_save;
    wr(4'h1, 32'h3);
    wr(4'h4, 32'h4);
    #1 chk("save", 32'h1, 32'(nv_save_o));
    chk("nv mask", 32'h3, 32'(nv_mask_o));
    chk("nv latch", 32'h6, 32'(nv_latch_o));
  endtask
  task automatic stop_test;
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset();
    t_mask();
    t_follow();
    t_latch();
    t_save();
    stop_test();
  end
endmodule
`default_nettype wire
